//--- rtl/irqcrc_crc_if.sv
// Link between the register front end and the checksum engine
`timescale 1ns/1ps
interface irqcrc_crc_if #(
    parameter int ADDR_W = 16
);
    logic start;               // One-cycle launch pulse
    logic [15:0] start_addr;   // Even first byte address
    logic [15:0] length;       // Even byte count
    logic busy;                // Calculation running
    logic done;                // One-cycle completion pulse
    logic [15:0] result;       // Final checksum
    logic [ADDR_W-1:0] mem_addr; // Message memory byte address
    logic mem_rd;              // Memory read strobe
    logic [7:0] mem_data;      // Memory byte, taken at edge ending strobe

    // Register side launches and collects
    modport front (output start, output start_addr, output length,
                   input busy, input done, input result);
    // Engine side runs the calculation
    modport engine (input start, input start_addr, input length,
                    output busy, output done, output result,
                    output mem_addr, output mem_rd, input mem_data);
    // Memory hookup seen from the top
    modport memory (input mem_addr, input mem_rd, output mem_data);
endinterface : irqcrc_crc_if

//--- rtl/irqcrc_engine.sv
// Checksum engine that walks message memory one byte at a time
`timescale 1ns/1ps
module irqcrc_engine (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Link to the register front end and memory
    irqcrc_crc_if.engine crc
);

    irqcrc_pkg::irqcrc_state_t state; // Engine state
    logic [15:0] crc_reg;             // Running checksum
    logic [15:0] remaining;           // Bytes still to fold in
    logic [15:0] next_crc;            // Checksum after current byte

    // Current byte folded into the running value
    assign next_crc = irqcrc_pkg::crc_byte(crc_reg, crc.mem_data);

    // Sequencer: read a byte, fold it, advance; low byte of a word first
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= irqcrc_pkg::CRC_IDLE;
            crc_reg <= irqcrc_pkg::CRC_PRESET;
            remaining <= 16'h0000;
            crc.mem_addr <= '0;
            crc.mem_rd <= 1'b0;
            crc.busy <= 1'b0;
            crc.done <= 1'b0;
            crc.result <= irqcrc_pkg::RESET_RESULT;
        end else begin
            crc.done <= 1'b0;
            crc.mem_rd <= 1'b0;
            case (state)
                irqcrc_pkg::CRC_IDLE: begin
                    if (crc.start) begin
                        // Preset and load the even range
                        crc_reg <= irqcrc_pkg::CRC_PRESET;
                        crc.mem_addr <= $bits(crc.mem_addr)'(
                            {crc.start_addr[15:1], 1'b0});
                        remaining <= {crc.length[15:1], 1'b0};
                        crc.busy <= 1'b1;
                        if (crc.length[15:1] == 15'h0000) begin
                            // Empty range ends at once with the preset
                            crc.result <= irqcrc_pkg::CRC_PRESET;
                            crc.done <= 1'b1;
                            state <= irqcrc_pkg::CRC_SHIFT;
                            remaining <= 16'h0000;
                        end else begin
                            crc.mem_rd <= 1'b1;
                            state <= irqcrc_pkg::CRC_READ;
                        end
                    end
                end
                irqcrc_pkg::CRC_READ: begin
                    // Byte arrives this cycle; fold and advance
                    crc_reg <= next_crc;
                    remaining <= remaining - 16'h0001;
                    if (remaining == 16'h0001) begin
                        crc.result <= next_crc;
                        crc.done <= 1'b1;
                        state <= irqcrc_pkg::CRC_SHIFT;
                    end else begin
                        crc.mem_addr <= crc.mem_addr + 1'b1;
                        crc.mem_rd <= 1'b1;
                    end
                end
                irqcrc_pkg::CRC_SHIFT: begin
                    // Completion cycle: drop busy, return to idle
                    crc.busy <= 1'b0;
                    state <= irqcrc_pkg::CRC_IDLE;
                end
                default: begin
                    state <= irqcrc_pkg::CRC_IDLE;
                    crc.busy <= 1'b0;
                end
            endcase
        end
    end

endmodule : irqcrc_engine

//--- rtl/irqcrc_pkg.sv
// Constants, types and the checksum function of the interrupt and CRC unit
// Behaviour
// - Enabled pending flags ORed onto interrupt pin
// - Flag register reads one where pending
// - Writing one clears flag, zero leaves it
// - Bit 1 set at end of radio read
// - Bit 2 set at end of radio write
// - Bit 3 set when CRC result ready
// - Bit 4 set on parity fault in parity mode
// - Bit 5 set on message structure fault
// - Bit 7 set on any fatal device fault
// - 16-bit checksum over programmed memory range
// - Length bit 0 always taken as zero
// - Writing length high byte starts calculation
// - Start address is even, selects first location
// - Busy status bit is one while running
// - Result in read-only low and high bytes
// - CCITT polynomial, register preset to all ones
// - Busy indicator is status bit 1 at 0xFFFC
// - Enable register at 0xFFFA, same bit layout
package irqcrc_pkg;

    // Byte addresses of the register bytes
    localparam logic [15:0] ADDR_START_LO = 16'hFFF2;
    localparam logic [15:0] ADDR_START_HI = 16'hFFF3;
    localparam logic [15:0] ADDR_LEN_LO = 16'hFFF4;
    localparam logic [15:0] ADDR_LEN_HI = 16'hFFF5;
    localparam logic [15:0] ADDR_RESULT_LO = 16'hFFF6;
    localparam logic [15:0] ADDR_RESULT_HI = 16'hFFF7;
    localparam logic [15:0] ADDR_FLAGS_LO = 16'hFFF8;
    localparam logic [15:0] ADDR_FLAGS_HI = 16'hFFF9;
    localparam logic [15:0] ADDR_MASK_LO = 16'hFFFA;
    localparam logic [15:0] ADDR_MASK_HI = 16'hFFFB;
    localparam logic [15:0] ADDR_STATUS_LO = 16'hFFFC;
    localparam logic [15:0] ADDR_STATUS_HI = 16'hFFFD;

    // Flag bit positions
    localparam int FLAG_READ_DONE = 1;
    localparam int FLAG_WRITE_DONE = 2;
    localparam int FLAG_CRC_DONE = 3;
    localparam int FLAG_PARITY = 4;
    localparam int FLAG_MSG = 5;
    localparam int FLAG_FATAL = 7;

    // Status bit position of the busy indicator
    localparam int STATUS_CRC_BUSY = 1;

    // Flag positions that can ever be set
    localparam logic [15:0] FLAG_IMPLEMENTED = 16'h00BE;

    // Values after reset
    localparam logic [15:0] RESET_START = 16'h0000;
    localparam logic [15:0] RESET_LENGTH = 16'h0000;
    localparam logic [15:0] RESET_RESULT = 16'h0000;
    localparam logic [15:0] RESET_FLAGS = 16'h0000;
    localparam logic [15:0] RESET_MASK = 16'h0000;
    localparam logic [7:0] RESET_RDATA = 8'h00;

    // Checksum preset and generator polynomial x^16 + x^12 + x^5 + 1
    localparam logic [15:0] CRC_PRESET = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h1021;

    // Engine states, one-hot
    typedef enum logic [2:0] {
        CRC_IDLE = 3'h1,
        CRC_READ = 3'h2,
        CRC_SHIFT = 3'h4
    } irqcrc_state_t;

    // Folds one byte into the checksum, most significant bit first
    function automatic logic [15:0] crc_byte(input logic [15:0] crc_in,
                                             input logic [7:0] data);
        logic [15:0] c;
        c = crc_in ^ {data, 8'h00};
        for (int i = 0; i < 8; i++) begin
            if (c[15]) begin
                c = {c[14:0], 1'b0} ^ CRC_POLY;
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        return c;
    endfunction : crc_byte

endpackage : irqcrc_pkg

//--- rtl/irqcrc_top.sv
// Interrupt flags, interrupt enables and CRC registers behind the byte port
`timescale 1ns/1ps
module irqcrc_top #(
    parameter int ADDR_W = 16 // Message memory byte address width
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Register byte port from the serial interface
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Event pulses from the device core
    input wire logic radio_read_done_i,
    input wire logic radio_write_done_i,
    input wire logic parity_mode_on_i,
    input wire logic parity_mode_fault_i,
    input wire logic message_structure_fault_i,
    input wire logic device_fault_i,
    // Message memory read port
    output logic [ADDR_W-1:0] mem_addr_o,
    output logic mem_rd_o,
    input wire logic [7:0] mem_data_i,
    // Interrupt pin, active high
    output logic irq_o
);

    // Link to the checksum engine
    irqcrc_crc_if #(.ADDR_W(ADDR_W)) crc ();

    // Register state
    logic [15:0] crc_range_start;  // First byte of the range
    logic [15:0] crc_range_length; // Byte count of the range
    logic [15:0] crc_checksum_out; // Last finished checksum
    logic [15:0] irq_pending_flags; // Pending events
    logic [15:0] irq_mask_bits;    // Per-event enables

    // Decoded write strobes
    logic wr_start_lo;
    logic wr_start_hi;
    logic wr_len_lo;
    logic wr_len_hi;
    logic wr_flags_lo;
    logic wr_flags_hi;
    logic wr_mask_lo;
    logic wr_mask_hi;

    // Event sets and host clears
    logic [15:0] flag_set;
    logic [15:0] flag_clr;
    logic [15:0] next_flags;
    logic [7:0] next_rdata;

    // Write decode, one strobe per writable register byte
    always_comb begin
        wr_start_lo = reg_wr_i && (reg_addr_i == irqcrc_pkg::ADDR_START_LO);
        wr_start_hi = reg_wr_i && (reg_addr_i == irqcrc_pkg::ADDR_START_HI);
        wr_len_lo = reg_wr_i && (reg_addr_i == irqcrc_pkg::ADDR_LEN_LO);
        wr_len_hi = reg_wr_i && (reg_addr_i == irqcrc_pkg::ADDR_LEN_HI);
        wr_flags_lo = reg_wr_i && (reg_addr_i == irqcrc_pkg::ADDR_FLAGS_LO);
        wr_flags_hi = reg_wr_i && (reg_addr_i == irqcrc_pkg::ADDR_FLAGS_HI);
        wr_mask_lo = reg_wr_i && (reg_addr_i == irqcrc_pkg::ADDR_MASK_LO);
        wr_mask_hi = reg_wr_i && (reg_addr_i == irqcrc_pkg::ADDR_MASK_HI);
    end

    // Start address bytes; bit 0 stored but ignored by the engine
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            crc_range_start <= irqcrc_pkg::RESET_START;
        end else begin
            if (wr_start_lo) begin
                crc_range_start[7:0] <= reg_wdata_i;
            end
            if (wr_start_hi) begin
                crc_range_start[15:8] <= reg_wdata_i;
            end
        end
    end

    // Length bytes; bit 0 always reads and acts as zero
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            crc_range_length <= irqcrc_pkg::RESET_LENGTH;
        end else begin
            if (wr_len_lo) begin
                crc_range_length[7:0] <= {reg_wdata_i[7:1], 1'b0};
            end
            if (wr_len_hi) begin
                crc_range_length[15:8] <= reg_wdata_i;
            end
        end
    end

    // Launch: high length byte write starts a run when the engine is idle
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            crc.start <= 1'b0;
            crc.start_addr <= irqcrc_pkg::RESET_START;
            crc.length <= irqcrc_pkg::RESET_LENGTH;
        end else begin
            crc.start <= wr_len_hi && !crc.busy && !crc.start;
            if (wr_len_hi && !crc.busy && !crc.start) begin
                // Snapshot the range with the freshly written high byte
                crc.start_addr <= {crc_range_start[15:1], 1'b0};
                crc.length <= {reg_wdata_i, crc_range_length[7:1],
                               1'b0};
            end
        end
    end

    // Result register, refreshed on completion only
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            crc_checksum_out <= irqcrc_pkg::RESET_RESULT;
        end else if (crc.done) begin
            crc_checksum_out <= crc.result;
        end
    end

    // Events that set pending flags this cycle
    always_comb begin
        flag_set = 16'h0000;
        flag_set[irqcrc_pkg::FLAG_READ_DONE] = radio_read_done_i;
        flag_set[irqcrc_pkg::FLAG_WRITE_DONE] = radio_write_done_i;
        flag_set[irqcrc_pkg::FLAG_CRC_DONE] = crc.done;
        flag_set[irqcrc_pkg::FLAG_PARITY] =
            parity_mode_fault_i && parity_mode_on_i;
        flag_set[irqcrc_pkg::FLAG_MSG] = message_structure_fault_i;
        flag_set[irqcrc_pkg::FLAG_FATAL] = device_fault_i;
    end

    // Host clears: a one written in a flag byte clears that flag
    always_comb begin
        flag_clr = 16'h0000;
        if (wr_flags_lo) begin
            flag_clr[7:0] = reg_wdata_i;
        end
        if (wr_flags_hi) begin
            flag_clr[15:8] = reg_wdata_i;
        end
        // A set in the same cycle as a clear wins
        next_flags = ((irq_pending_flags & ~flag_clr) | flag_set)
                     & irqcrc_pkg::FLAG_IMPLEMENTED;
    end

    // Pending flag register
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_pending_flags <= irqcrc_pkg::RESET_FLAGS;
        end else begin
            irq_pending_flags <= next_flags;
        end
    end

    // Enable register, full 16 bits writable
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_mask_bits <= irqcrc_pkg::RESET_MASK;
        end else begin
            if (wr_mask_lo) begin
                irq_mask_bits[7:0] <= reg_wdata_i;
            end
            if (wr_mask_hi) begin
                irq_mask_bits[15:8] <= reg_wdata_i;
            end
        end
    end

    // Interrupt pin: OR of all enabled pending flags, registered
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(next_flags & irq_mask_bits);
        end
    end

    // Read mux for the register bytes; unknown addresses read zero
    always_comb begin
        next_rdata = irqcrc_pkg::RESET_RDATA;
        case (reg_addr_i)
            irqcrc_pkg::ADDR_START_LO: begin
                next_rdata = crc_range_start[7:0];
            end
            irqcrc_pkg::ADDR_START_HI: begin
                next_rdata = crc_range_start[15:8];
            end
            irqcrc_pkg::ADDR_LEN_LO: begin
                next_rdata = crc_range_length[7:0];
            end
            irqcrc_pkg::ADDR_LEN_HI: begin
                next_rdata = crc_range_length[15:8];
            end
            irqcrc_pkg::ADDR_RESULT_LO: begin
                next_rdata = crc_checksum_out[7:0];
            end
            irqcrc_pkg::ADDR_RESULT_HI: begin
                next_rdata = crc_checksum_out[15:8];
            end
            irqcrc_pkg::ADDR_FLAGS_LO: begin
                next_rdata = irq_pending_flags[7:0];
            end
            irqcrc_pkg::ADDR_FLAGS_HI: begin
                next_rdata = irq_pending_flags[15:8];
            end
            irqcrc_pkg::ADDR_MASK_LO: begin
                next_rdata = irq_mask_bits[7:0];
            end
            irqcrc_pkg::ADDR_MASK_HI: begin
                next_rdata = irq_mask_bits[15:8];
            end
            irqcrc_pkg::ADDR_STATUS_LO: begin
                // Busy also shows in the launch cycle
                next_rdata[irqcrc_pkg::STATUS_CRC_BUSY] =
                    crc.busy || crc.start;
            end
            default: begin
                next_rdata = irqcrc_pkg::RESET_RDATA;
            end
        endcase
    end

    // Read data register, loaded on a read strobe and held after
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= irqcrc_pkg::RESET_RDATA;
        end else if (reg_rd_i) begin
            reg_rdata_o <= next_rdata;
        end
    end

    // Memory port, engine flip-flops passed to the pins
    assign mem_addr_o = crc.mem_addr;
    assign mem_rd_o = crc.mem_rd;
    assign crc.mem_data = mem_data_i;

    // Checksum engine
    irqcrc_engine u_engine (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .crc(crc.engine)
    );

endmodule : irqcrc_top

//--- verif/irqcrc_mem_model.sv
// Message memory model answering the unit's byte read port
`timescale 1ns/1ps
module irqcrc_mem_model #(
    parameter int ADDR_W = 16
) (
    // Clock
    input wire logic clk_sys_i,
    // Read port
    input wire logic [ADDR_W-1:0] mem_addr_i,
    input wire logic mem_rd_i,
    output logic [7:0] mem_data_o
);
    logic [7:0] junk; // Filler shown while no read is strobed
    // Filler toggles every cycle so a mistimed sample shows up
    initial junk = 8'h00;
    always @(posedge clk_sys_i) begin
        junk <= ~junk;
    end
    // Byte of the strobed address, taken at the edge closing the strobe
    assign mem_data_o = mem_rd_i ? (mem_addr_i[7:0] ^ 8'h3C) : junk;
endmodule : irqcrc_mem_model

//--- verif/irqcrc_props.sv
// Concurrent checks on the ports of the interrupt and CRC unit
`timescale 1ns/1ps
module irqcrc_props #(
    parameter int ADDR_W = 16
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Register byte port
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    // Event inputs
    input wire logic radio_read_done_i,
    input wire logic radio_write_done_i,
    input wire logic parity_mode_on_i,
    input wire logic parity_mode_fault_i,
    input wire logic message_structure_fault_i,
    input wire logic device_fault_i,
    // Memory port and interrupt
    input wire logic [ADDR_W-1:0] mem_addr_o,
    input wire logic mem_rd_o,
    input wire logic [7:0] mem_data_i,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    logic [7:0] mask_lo; // Mirror of the low enable byte
    logic keep; // No low enable byte write in this cycle
    assign keep = !(reg_wr_i && reg_addr_i == irqcrc_pkg::ADDR_MASK_LO);
    // Follows host writes to the low enable byte
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mask_lo <= 8'h00;
        end else if (!keep) begin
            mask_lo <= reg_wdata_i;
        end
    end
    a_read_done_irq: assert property (
        radio_read_done_i && mask_lo[1] && keep |=> irq_o)
        else $error("Radio read end did not raise the interrupt");
    a_write_done_irq: assert property (
        radio_write_done_i && mask_lo[2] && keep |=> irq_o)
        else $error("Radio write end did not raise the interrupt");
    a_parity_irq: assert property (
        parity_mode_fault_i && parity_mode_on_i && mask_lo[4] && keep
        |=> irq_o)
        else $error("Parity fault did not raise the interrupt");
    a_msg_fault_irq: assert property (
        message_structure_fault_i && mask_lo[5] && keep |=> irq_o)
        else $error("Message fault did not raise the interrupt");
    a_fatal_irq: assert property (
        device_fault_i && mask_lo[7] && keep |=> irq_o)
        else $error("Device fault did not raise the interrupt");
    a_high_flags_zero: assert property (
        reg_rd_i && reg_addr_i == irqcrc_pkg::ADDR_FLAGS_HI
        |=> reg_rdata_o == 8'h00)
        else $error("Upper flag byte read nonzero");
    a_crc_launch: assert property (
        $rose(mem_rd_o)
        |-> $past(reg_wr_i && reg_addr_i == irqcrc_pkg::ADDR_LEN_HI, 2))
        else $error("Memory walk began without a length high write");
    a_even_start: assert property (
        $rose(mem_rd_o) |-> !mem_addr_o[0])
        else $error("Memory walk began at an odd address");
    a_addr_step: assert property (
        mem_rd_o && $past(mem_rd_o) |-> mem_addr_o == $past(mem_addr_o) + 1'b1)
        else $error("Memory walk skipped an address");
    a_busy_shown: assert property (
        reg_rd_i && reg_addr_i == irqcrc_pkg::ADDR_STATUS_LO && mem_rd_o
        |=> reg_rdata_o[1])
        else $error("Busy bit low while the memory walk runs");
endmodule : irqcrc_props

bind irqcrc_top irqcrc_props #(.ADDR_W(ADDR_W)) i_props (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .radio_read_done_i(radio_read_done_i),
    .radio_write_done_i(radio_write_done_i),
    .parity_mode_on_i(parity_mode_on_i),
    .parity_mode_fault_i(parity_mode_fault_i),
    .message_structure_fault_i(message_structure_fault_i),
    .device_fault_i(device_fault_i), .mem_addr_o(mem_addr_o),
    .mem_rd_o(mem_rd_o), .mem_data_i(mem_data_i), .irq_o(irq_o)
);

//--- verif/irqcrc_top_tb.sv
// Self-checking bench for the interrupt and CRC unit
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
        fails++; \
        $display("[FAIL] %0t got %h expected %h", $time, got, exp); \
    end \
end
module irqcrc_top_tb;
    // Clock, reset and counters
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    int fails = 0;
    int num_checks = 0;
    // Register port
    logic [15:0] reg_addr_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic [7:0] rb; // Last byte read
    // Events: read end, write end, parity, message, fatal
    logic [4:0] ev = 5'h00;
    logic parity_on = 1'b0;
    // Memory port, interrupt and expected checksum
    logic [15:0] mem_addr_o;
    logic mem_rd_o;
    logic [7:0] mem_data_i;
    logic irq_o;
    logic [15:0] exp_crc;
    int flag_pos[5] = '{1, 2, 4, 5, 7}; // Flag bit of each event

    always #25 clk_sys_i = ~clk_sys_i;

    irqcrc_top #(.ADDR_W(16)) i_dut (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .radio_read_done_i(ev[0]),
        .radio_write_done_i(ev[1]), .parity_mode_on_i(parity_on),
        .parity_mode_fault_i(ev[2]), .message_structure_fault_i(ev[3]),
        .device_fault_i(ev[4]), .mem_addr_o(mem_addr_o),
        .mem_rd_o(mem_rd_o), .mem_data_i(mem_data_i), .irq_o(irq_o)
    );
    irqcrc_mem_model #(.ADDR_W(16)) i_mem (
        .clk_sys_i(clk_sys_i), .mem_addr_i(mem_addr_o),
        .mem_rd_i(mem_rd_o), .mem_data_o(mem_data_i)
    );

    // Bitwise reference over the memory pattern, MSB first
    function automatic logic [15:0] crc_ref(input logic [15:0] a,
                                            input logic [15:0] n);
        logic [15:0] c;
        logic [7:0] d;
        c = 16'hFFFF;
        for (int k = 0; k < n; k++) begin
            d = (a[7:0] + k[7:0]) ^ 8'h3C;
            for (int i = 7; i >= 0; i--) begin
                c = {c[14:0], 1'b0} ^ ({16{c[15] ^ d[i]}} & 16'h1021);
            end
        end
        return c;
    endfunction : crc_ref
    // Byte write, strobe held over one rising edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clk_sys_i);
        reg_wr_i = 1'b0;
    endtask : wr
    // Byte read, data registered by the following falling edge
    task automatic rd(input logic [15:0] a);
        @(negedge clk_sys_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge clk_sys_i);
        reg_rd_i = 1'b0;
        rb = reg_rdata_o;
    endtask : rd
    // Read a byte and compare it
    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        rd(a);
        `CHK(rb, e)
    endtask : rchk
    // One-cycle pulse on one event input
    task automatic pulse(input int k);
        @(negedge clk_sys_i);
        ev[k] = 1'b1;
        @(negedge clk_sys_i);
        ev[k] = 1'b0;
    endtask : pulse
    // Prints counts and verdict, then stops
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    // Launch a run, wait for its flag, check result and pin
    task automatic crc_run(input logic [15:0] a, input logic [15:0] n);
        int t;
        exp_crc = crc_ref({a[15:1], 1'b0}, {n[15:1], 1'b0});
        wr(irqcrc_pkg::ADDR_START_LO, a[7:0]);
        wr(irqcrc_pkg::ADDR_START_HI, a[15:8]);
        wr(irqcrc_pkg::ADDR_LEN_LO, n[7:0]);
        wr(irqcrc_pkg::ADDR_LEN_HI, n[15:8]);
        if (n[15:1] != 15'h0000) begin
            rchk(irqcrc_pkg::ADDR_STATUS_LO, 8'h02);
        end
        t = 0;
        rb = 8'h00;
        while (rb[3] !== 1'b1 && t < 400) begin
            rd(irqcrc_pkg::ADDR_FLAGS_LO);
            t++;
        end
        if (t >= 400) begin
            fails++;
            $display("[FAIL] %0t completion flag never set", $time);
            test_done();
        end
        `CHK(irq_o, 1'b1)
        rchk(irqcrc_pkg::ADDR_STATUS_LO, 8'h00);
        rchk(irqcrc_pkg::ADDR_RESULT_LO, exp_crc[7:0]);
        rchk(irqcrc_pkg::ADDR_RESULT_HI, exp_crc[15:8]);
        wr(irqcrc_pkg::ADDR_FLAGS_LO, 8'h08);
    endtask : crc_run

    // Main sequence
    initial begin
        repeat (12) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        resetn_i = 1'b1;
        // All register bytes and two unmapped bytes read zero
        for (int a = 16'hFFF0; a <= 16'hFFFD; a++) begin
            rchk(a[15:0], 8'h00);
        end
        wr(irqcrc_pkg::ADDR_MASK_HI, 8'hA5);
        rchk(irqcrc_pkg::ADDR_MASK_HI, 8'hA5);
        wr(irqcrc_pkg::ADDR_MASK_LO, 8'hFF);
        rchk(irqcrc_pkg::ADDR_MASK_LO, 8'hFF);
        parity_on = 1'b1;
        // Each event sets its flag and the pin; zero write keeps it
        foreach (flag_pos[k]) begin
            pulse(k);
            `CHK(irq_o, 1'b1)
            wr(irqcrc_pkg::ADDR_FLAGS_LO, 8'h00);
            rchk(irqcrc_pkg::ADDR_FLAGS_LO, 8'h01 << flag_pos[k]);
            wr(irqcrc_pkg::ADDR_FLAGS_LO, 8'h01 << flag_pos[k]);
            rchk(irqcrc_pkg::ADDR_FLAGS_LO, 8'h00);
            `CHK(irq_o, 1'b0)
        end
        // Parity fault outside parity mode is ignored
        parity_on = 1'b0;
        pulse(2);
        rchk(irqcrc_pkg::ADDR_FLAGS_LO, 8'h00);
        // Masked event pends quietly until its enable is set
        wr(irqcrc_pkg::ADDR_MASK_LO, 8'h7F);
        pulse(4);
        rchk(irqcrc_pkg::ADDR_FLAGS_LO, 8'h80);
        `CHK(irq_o, 1'b0)
        wr(irqcrc_pkg::ADDR_MASK_LO, 8'h80);
        wr(irqcrc_pkg::ADDR_FLAGS_HI, 8'hFF);
        `CHK(irq_o, 1'b1)
        rchk(irqcrc_pkg::ADDR_FLAGS_HI, 8'h00);
        wr(irqcrc_pkg::ADDR_FLAGS_LO, 8'h80);
        // Checksum runs, radio side kept off throughout
        wr(irqcrc_pkg::ADDR_MASK_LO, 8'h08);
        crc_run(16'h0011, 16'h0007);
        rchk(irqcrc_pkg::ADDR_LEN_LO, 8'h06);
        wr(irqcrc_pkg::ADDR_RESULT_LO, 8'h12);
        rchk(irqcrc_pkg::ADDR_RESULT_LO, exp_crc[7:0]);
        crc_run(16'h0100, 16'h0000);
        crc_run(16'h0FFE, 16'h0102);
        test_done();
    end
endmodule : irqcrc_top_tb
